// >>> logic/cdis_pkg.sv
// Purpose: Shared constants for the card dual interface switch.
// Assumes: 32-bit register bus, one word per register index.
// Notes:   Byte address of a register is four times its index.
package cdis_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CDIS_CLK_NS          = 8;
  localparam int unsigned CDIS_REFCLK_STALL_NS = 1000;
  localparam int unsigned CDIS_REFCLK_STALL_CYC =
    (CDIS_REFCLK_STALL_NS + CDIS_CLK_NS - 1) / CDIS_CLK_NS;

  // ****************************************************************
  // Register map (indices; byte address = index * 4)
  // ****************************************************************
  localparam int unsigned CDIS_ADDR_W     = 12;
  localparam int unsigned CDIS_IDX_W      = CDIS_ADDR_W - 2;
  localparam logic [9:0] IDX_SUPPLY_CTRL  = 10'h029;
  localparam logic [9:0] IDX_CAPS_LO      = 10'h040;
  localparam logic [9:0] IDX_CAPS_HI      = 10'h041;
  localparam logic [9:0] IDX_ALT_LINK     = 10'h055;
  localparam logic [9:0] IDX_EVT_STATUS   = 10'h060;
  localparam logic [9:0] IDX_EVT_MASK     = 10'h061;
  localparam logic [9:0] IDX_PIN_STATE    = 10'h062;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned SUP_FIRST_BIT   = 0;
  localparam int unsigned SUP_SECOND_BIT  = 4;
  localparam int unsigned ALT_PRESENT_BIT = 0;
  localparam int unsigned ALT_SELECT_BIT  = 1;
  localparam int unsigned CAP_DUAL_BIT    = 20;
  localparam int unsigned CAP_LOWRAIL_BIT = 60;
  localparam int unsigned CAP_HI_BASE     = 32;

  // Event bits, shared by status and mask
  localparam int unsigned EV_W            = 4;
  localparam int unsigned EV_INSERT       = 0;
  localparam int unsigned EV_REMOVE       = 1;
  localparam int unsigned EV_CLKREQ       = 2;
  localparam int unsigned EV_REFSTALL     = 3;

  // Pin state word
  localparam int unsigned PS_PRESENT      = 0;
  localparam int unsigned PS_FIRST        = 1;
  localparam int unsigned PS_SECOND       = 2;
  localparam int unsigned PS_MODE         = 3;
  localparam int unsigned PS_PRSNT_N      = 4;
  localparam int unsigned PS_CLKREQ_N     = 5;
  localparam int unsigned PS_REF_ACTIVE   = 6;

  // ****************************************************************
  // Reset values and bus answers
  // ****************************************************************
  localparam logic [7:0]  SUPPLY_RST      = 8'h00;
  localparam logic [7:0]  ALT_LINK_RST    = 8'h00;
  localparam logic [3:0]  EVT_RST         = 4'h0;
  localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  // Rail sequencing states, Gray along off -> first -> both
  typedef enum logic [1:0] {
    CDIS_RAIL_OFF   = 2'b00,
    CDIS_RAIL_FIRST = 2'b01,
    CDIS_RAIL_BOTH  = 2'b11
  } cdis_rail_t;

endpackage

// >>> logic/cdis_sync.sv
// Purpose: Two-flop synchroniser for pin levels.
// Assumes: Inputs are asynchronous to aclk.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
module cdis_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cdis_sync_st_t;

  cdis_sync_st_t s_q;
  cdis_sync_st_t s_d;

  if (W < 1)
  begin
    $error("cdis_sync: W must be at least 1");
  end

  // First stage feeds only the second
  always_comb
  begin
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
  end

  // Reset loads ones: idle level of every synced pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '1;
    else
      s_q <= s_d;
  end

  assign q = s_q.s2;

endmodule

// >>> logic/cdis_top.sv
// Purpose: Register-controlled front end sharing card contacts
//          between the legacy card bus and a one-lane serial link.
// Assumes: AXI4-Lite slave at 125 MHz; pins are asynchronous.
// Notes:   The contact switch itself is a combinational path.
//
// What this block does
// - Contacts 0 and 1 carry reference clock pair or card data 0/1.
// - Fundamental reset drives contact 3 as a plain output in link mode.
// - Clock request on contact 2 is open drain, pulled up on the card side.
// - Only one function reaches the shared contacts at any time.
// - Second-supply bit powers the rail and, unless SEPARATE_SELECT is set, selects link mode.
// - Link enable at one drives presence-detect low to link block.
// - Link enable at zero drives presence-detect high, meaning removal.
// - Capability bit 20 reads one: dual interface supported.
// - With bit 20 set, low-rail capability bit 60 reads one too.
// - Second supply is off whenever a card is being inserted.
// - Second supply turns on only after the first rail is on.
// - Card presence comes from the socket switch, not the link.
// - Mode select may follow second supply or a separate bit.
// - Supplies drop when the card leaves the socket.
`timescale 1ns/1ps
module cdis_top #(
  parameter bit          SEPARATE_SELECT  = 1'b0,
  parameter int unsigned REFCLK_STALL_CYC =
    cdis_pkg::CDIS_REFCLK_STALL_CYC
) (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [cdis_pkg::CDIS_ADDR_W-1:0] awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  // AXI4-Lite write response
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  // AXI4-Lite read
  input  wire logic [cdis_pkg::CDIS_ADDR_W-1:0] araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  // Shared card contacts
  input  wire logic [3:0]                  card_dat_i,
  output logic      [3:0]                  card_dat_o,
  output logic      [3:0]                  card_dat_oe,
  input  wire logic                        card_detect_n,
  // Legacy card controller side
  input  wire logic [3:0]                  sdc_dat_o,
  input  wire logic [3:0]                  sdc_dat_oe,
  output logic      [3:0]                  sdc_dat_i,
  output logic                             sdc_card_detect_n,
  // Serial link block side
  input  wire logic                        refclk_p,
  input  wire logic                        refclk_n,
  input  wire logic                        perst_n,
  input  wire logic                        clkreq_pull,
  output logic                             clkreq_n_sense,
  output logic                             prsnt_n,
  // Power and switch control
  output logic                             first_supply_en,
  output logic                             second_supply_en,
  output logic                             mode_pcie,
  // Interrupt
  output logic                             irq
);
  import cdis_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                  aw_ok;
    logic [CDIS_IDX_W-1:0] aw_idx;
    logic                  w_ok;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    cdis_rail_t            rail;
    logic                  link_en;
    logic                  link_sel;
    logic                  prsnt_n;
    logic                  mode;
    logic [EV_W-1:0]       sts;
    logic [EV_W-1:0]       msk;
    logic                  cd_prev;
    logic                  clkreq_prev;
    logic                  ref_prev;
    logic [15:0]           ref_cnt;
    logic                  ref_active;
    logic                  irq;
  } cdis_st_t;

  cdis_st_t s_q;
  cdis_st_t s_d;

  logic [2:0] sync_q;
  logic       cd_n_s;
  logic       ref_s;
  logic       clkreq_s;

  // Refuse stall counts the 16-bit counter cannot serve
  if (REFCLK_STALL_CYC < 2 || REFCLK_STALL_CYC > 65535)
  begin
    $error("cdis_top: REFCLK_STALL_CYC out of range");
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  cdis_sync #(
    .W (3)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({card_detect_n, refclk_p, card_dat_i[2]}),
    .q       (sync_q)
  );

  assign cd_n_s   = sync_q[2];
  assign ref_s    = sync_q[1];
  assign clkreq_s = sync_q[0];

  // ****************************************************************
  // Contact switch
  // ****************************************************************
  // One function at a time on the shared contacts
  always_comb
  begin
    if (s_q.mode)
    begin
      card_dat_o  = {perst_n, 1'b0, refclk_n, refclk_p};
      card_dat_oe = {1'b1, clkreq_pull, 1'b1, 1'b1};
      sdc_dat_i   = 4'hf;
    end
    else
    begin
      card_dat_o  = sdc_dat_o;
      card_dat_oe = sdc_dat_oe;
      sdc_dat_i   = card_dat_i;
    end
  end

  // ****************************************************************
  // Bus handshakes and registered outputs
  // ****************************************************************
  assign awready           = aresetn && !s_q.aw_ok && !s_q.bvalid;
  assign wready            = aresetn && !s_q.w_ok && !s_q.bvalid;
  assign arready           = aresetn && !s_q.rvalid;
  assign bvalid            = s_q.bvalid;
  assign bresp             = s_q.bresp;
  assign rvalid            = s_q.rvalid;
  assign rdata             = s_q.rdata;
  assign rresp             = s_q.rresp;
  assign prsnt_n           = s_q.prsnt_n;
  assign mode_pcie         = s_q.mode;
  assign first_supply_en   = s_q.rail != CDIS_RAIL_OFF;
  assign second_supply_en  = s_q.rail == CDIS_RAIL_BOTH;
  assign sdc_card_detect_n = cd_n_s;
  assign clkreq_n_sense    = s_q.clkreq_prev;
  assign irq               = s_q.irq;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    logic                  have_aw;
    logic                  have_w;
    logic [CDIS_IDX_W-1:0] widx;
    logic [31:0]           wd;
    logic                  wlo;
    logic [EV_W-1:0]       ev;
    logic [EV_W-1:0]       clr;
    logic                  present;
    logic                  ref_edge;
    logic                  req_first;
    logic                  req_second;
    logic [31:0]           rd;
    logic                  hit;

    s_d        = s_q;
    have_aw    = s_q.aw_ok || (awvalid && awready);
    have_w     = s_q.w_ok || (wvalid && wready);
    widx       = s_q.aw_ok ? s_q.aw_idx : awaddr[CDIS_ADDR_W-1:2];
    wd         = s_q.w_ok ? s_q.w_data : wdata;
    wlo        = s_q.w_ok ? s_q.w_strb[0] : wstrb[0];
    ev         = '0;
    clr        = '0;
    present    = !cd_n_s;
    ref_edge   = ref_s != s_q.ref_prev;
    req_first  = 1'b0;
    req_second = 1'b0;
    rd         = WORD_ZERO;
    hit        = 1'b1;

    // Catch address and data, in either order
    if (awvalid && awready)
    begin
      s_d.aw_ok  = 1'b1;
      s_d.aw_idx = awaddr[CDIS_ADDR_W-1:2];
    end
    if (wvalid && wready)
    begin
      s_d.w_ok   = 1'b1;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end
    if (s_q.bvalid && bready)
      s_d.bvalid = 1'b0;

    // Register writes, committed once both halves are in
    if (have_aw && have_w && !s_q.bvalid)
    begin
      s_d.aw_ok  = 1'b0;
      s_d.w_ok   = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OKAY;
      case (widx)
        IDX_SUPPLY_CTRL:
        begin
          if (wlo)
          begin
            req_first  = wd[SUP_FIRST_BIT];
            req_second = wd[SUP_SECOND_BIT];
            // Second rail only once the first is already up
            if (!req_first)
              s_d.rail = CDIS_RAIL_OFF;
            else if (req_second && s_q.rail != CDIS_RAIL_OFF)
              s_d.rail = CDIS_RAIL_BOTH;
            else
              s_d.rail = CDIS_RAIL_FIRST;
          end
        end
        IDX_ALT_LINK:
        begin
          if (wlo)
          begin
            s_d.link_en  = wd[ALT_PRESENT_BIT];
            s_d.link_sel = wd[ALT_SELECT_BIT];
          end
        end
        IDX_EVT_STATUS:
        begin
          if (wlo)
            clr = wd[EV_W-1:0];
        end
        IDX_EVT_MASK:
        begin
          if (wlo)
            s_d.msk = wd[EV_W-1:0];
        end
        IDX_CAPS_LO, IDX_CAPS_HI, IDX_PIN_STATE:
          s_d.bresp = RESP_OKAY;
        default:
          s_d.bresp = RESP_SLVERR;
      endcase
    end

    // Socket switch edges raise insert and remove events
    if (!present)
    begin
      // No card: no power, link told the card is gone
      s_d.rail    = CDIS_RAIL_OFF;
      s_d.link_en = 1'b0;
    end
    if (s_q.cd_prev && !cd_n_s)
      ev[EV_INSERT] = 1'b1;
    if (!s_q.cd_prev && cd_n_s)
      ev[EV_REMOVE] = 1'b1;
    s_d.cd_prev = cd_n_s;

    // Clock request contact pulled low, by card or host, while in link mode
    if (s_q.mode && s_q.clkreq_prev && !clkreq_s)
      ev[EV_CLKREQ] = 1'b1;
    s_d.clkreq_prev = clkreq_s;

    // Reference clock watchdog, sampled on aclk
    s_d.ref_prev = ref_s;
    if (!s_q.mode || ref_edge)
    begin
      s_d.ref_cnt    = '0;
      s_d.ref_active = s_q.mode && ref_edge;
    end
    else if (s_q.ref_cnt != 16'(REFCLK_STALL_CYC - 1))
      s_d.ref_cnt = s_q.ref_cnt + 16'h0001;
    else if (s_q.ref_active)
    begin
      s_d.ref_active      = 1'b0;
      ev[EV_REFSTALL] = 1'b1;
    end

    // Switch select and presence line from next control state
    if (SEPARATE_SELECT)
      s_d.mode = s_d.link_sel;
    else
      s_d.mode = s_d.rail == CDIS_RAIL_BOTH;
    s_d.prsnt_n = !s_d.link_en;

    // Sticky events; a new event beats the clear
    s_d.sts = (s_q.sts & ~clr) | ev;
    s_d.irq = |(s_d.sts & s_d.msk);

    // Read path, one word per index
    case (araddr[CDIS_ADDR_W-1:2])
      IDX_SUPPLY_CTRL:
      begin
        rd[SUP_FIRST_BIT]  = s_q.rail != CDIS_RAIL_OFF;
        rd[SUP_SECOND_BIT] = s_q.rail == CDIS_RAIL_BOTH;
      end
      IDX_CAPS_LO:
        rd[CAP_DUAL_BIT] = 1'b1;
      IDX_CAPS_HI:
        rd[CAP_LOWRAIL_BIT - CAP_HI_BASE] = 1'b1;
      IDX_ALT_LINK:
      begin
        rd[ALT_PRESENT_BIT] = s_q.link_en;
        rd[ALT_SELECT_BIT]  = s_q.link_sel;
      end
      IDX_EVT_STATUS:
        rd[EV_W-1:0] = s_q.sts;
      IDX_EVT_MASK:
        rd[EV_W-1:0] = s_q.msk;
      IDX_PIN_STATE:
      begin
        rd[PS_PRESENT]    = present;
        rd[PS_FIRST]      = s_q.rail != CDIS_RAIL_OFF;
        rd[PS_SECOND]     = s_q.rail == CDIS_RAIL_BOTH;
        rd[PS_MODE]       = s_q.mode;
        rd[PS_PRSNT_N]    = s_q.prsnt_n;
        rd[PS_CLKREQ_N]   = s_q.clkreq_prev;
        rd[PS_REF_ACTIVE] = s_q.ref_active;
      end
      default:
        hit = 1'b0;
    endcase
    if (arvalid && arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd;
      s_d.rresp  = hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_q.rvalid && rready)
      s_d.rvalid = 1'b0;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset leaves legacy mode, rails off, presence high
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q             <= '0;
      s_q.rail        <= CDIS_RAIL_OFF;
      s_q.link_en     <= ALT_LINK_RST[ALT_PRESENT_BIT];
      s_q.link_sel    <= ALT_LINK_RST[ALT_SELECT_BIT];
      s_q.prsnt_n     <= 1'b1;
      s_q.sts         <= EVT_RST;
      s_q.msk         <= EVT_RST;
      s_q.cd_prev     <= 1'b1;
      s_q.clkreq_prev <= 1'b1;
    end
    else
      s_q <= s_d;
  end

endmodule

// >>> sim/cdis_card_model.sv
// Purpose: Behavioural card seated in the shared socket.
// Assumes: Host resolves nothing; this model makes contact levels.
// Notes:   Released contacts of an empty socket show a toggling pattern, not a hold.
`timescale 1ns/1ps
module cdis_card_model (
  // Clock for the idle pattern
  input  wire logic       aclk,
  // Bench commands
  input  wire logic       inserted,
  input  wire logic       card_pull,
  input  wire logic [3:0] sd_reply,
  // Host side of the contacts
  input  wire logic       second_supply_en,
  input  wire logic [3:0] card_dat_o,
  input  wire logic [3:0] card_dat_oe,
  output logic      [3:0] card_dat_i,
  output logic            card_detect_n
);
  logic [3:0] tog_q = 4'h5;

  // Pattern on floating contacts
  always_ff @(posedge aclk)
    tog_q <= ~tog_q;

  // Contact resolution and socket switch
  always_comb
  begin
    card_detect_n = ~inserted;
    for (int i = 0; i < 4; i++)
      card_dat_i[i] = card_dat_oe[i] ? card_dat_o[i]
                    : (inserted ? sd_reply[i] : tog_q[i]);
    // Second rail moves the card to link mode, contact 2 open drain
    if (second_supply_en)
      card_dat_i[2] = ~(card_dat_oe[2] | (card_pull & inserted));
  end
endmodule

// >>> sim/cdis_properties.sv
// Purpose: Port-level checks of the card dual interface switch.
// Assumes: Bound into cdis_top; sees its ports only.
// Notes:   Mode check is skipped when a separate select is built.
`timescale 1ns/1ps
module cdis_properties #(
  parameter bit SEPARATE_SELECT = 1'h0
) (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Contacts and legacy side
  input wire logic [3:0] card_dat_i,
  input wire logic [3:0] card_dat_o,
  input wire logic [3:0] card_dat_oe,
  input wire logic [3:0] sdc_dat_o,
  input wire logic [3:0] sdc_dat_oe,
  input wire logic [3:0] sdc_dat_i,
  input wire logic       card_detect_n,
  input wire logic       sdc_card_detect_n,
  // Link side and power
  input wire logic       refclk_p,
  input wire logic       perst_n,
  input wire logic       clkreq_pull,
  input wire logic       prsnt_n,
  input wire logic       first_supply_en,
  input wire logic       second_supply_en,
  input wire logic       mode_pcie
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_mode_rail: assert property (
    SEPARATE_SELECT || mode_pcie == second_supply_en)
    else $error("mode select differs from second rail");
  chk_rail_order: assert property (
    second_supply_en |-> first_supply_en && $past(first_supply_en))
    else $error("second rail on without first rail");
  chk_link_pins: assert property (
    mode_pcie |-> card_dat_oe[3] && card_dat_o[3] == perst_n
      && card_dat_oe[0] && card_dat_o[0] == refclk_p)
    else $error("link pins not routed");
  chk_clkreq_drain: assert property (
    mode_pcie |-> card_dat_oe[2] == clkreq_pull && !card_dat_o[2])
    else $error("clock request not open drain");
  chk_legacy_route: assert property (
    !mode_pcie |-> card_dat_o == sdc_dat_o && card_dat_oe == sdc_dat_oe
      && sdc_dat_i == card_dat_i)
    else $error("legacy path not routed");
  chk_link_isolate: assert property (
    mode_pcie |-> sdc_dat_i == 4'hf)
    else $error("legacy side not isolated");
  chk_detect_sync: assert property (
    $past(aresetn) && $past(aresetn, 2) |->
      sdc_card_detect_n == $past(card_detect_n, 2))
    else $error("card detect not passed on");
  chk_rail_absent: assert property (
    sdc_card_detect_n [*3] |-> !first_supply_en && !second_supply_en)
    else $error("rail on with no card");
  chk_prsnt_absent: assert property (
    sdc_card_detect_n [*3] |-> prsnt_n)
    else $error("presence asserted with no card");
endmodule

bind cdis_top cdis_properties #(.SEPARATE_SELECT(SEPARATE_SELECT)) chk_u (
  .aclk, .aresetn, .card_dat_i, .card_dat_o, .card_dat_oe, .sdc_dat_o,
  .sdc_dat_oe, .sdc_dat_i, .card_detect_n, .sdc_card_detect_n, .refclk_p,
  .perst_n, .clkreq_pull, .prsnt_n, .first_supply_en, .second_supply_en,
  .mode_pcie);

// >>> sim/tb_top.sv
// Purpose: Self-checking bench for the card dual interface switch.
// Assumes: Bench is the register bus master; card model on contacts.
// Notes:   Stall count shortened to 32 cycles; link clock 160 ns.
`timescale 1ns/1ps
module tb_top;
  import cdis_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hf, sdc_dat_o = 4'h0, sdc_dat_oe = 4'h0;
  logic [3:0]  sd_reply = 4'h0, card_dat_i, card_dat_o, card_dat_oe;
  logic [3:0]  sdc_dat_i;
  logic [1:0]  bresp, rresp;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, perst_n = 1'h1;
  logic        clkreq_pull = 1'h0, refclk_p = 1'h0, refclk_n = 1'h1;
  logic        inserted = 1'h0, card_pull = 1'h0, ref_run = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, card_detect_n;
  logic        sdc_card_detect_n, clkreq_n_sense, prsnt_n, irq;
  logic        first_supply_en, second_supply_en, mode_pcie;
  int          errors = 0, tests_run = 0, cyc = 0;

  cdis_top #(.REFCLK_STALL_CYC(32)) dut_u (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .card_dat_i, .card_dat_o, .card_dat_oe,
    .card_detect_n, .sdc_dat_o, .sdc_dat_oe, .sdc_dat_i, .sdc_card_detect_n,
    .refclk_p, .refclk_n, .perst_n, .clkreq_pull, .clkreq_n_sense, .prsnt_n,
    .first_supply_en, .second_supply_en, .mode_pcie, .irq);
  cdis_card_model card_u (
    .aclk, .inserted, .card_pull, .sd_reply, .second_supply_en,
    .card_dat_o, .card_dat_oe, .card_dat_i, .card_detect_n);

  // Bus clock, and link clock that stands still outside frames
  initial
    forever #4 aclk = ~aclk;
  initial
  begin
    #3;
    forever
    begin
      #80;
      if (ref_run) refclk_p = ~refclk_p;
      refclk_n = ~refclk_p;
    end
  end

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask

  task automatic wr(input logic [9:0] ix, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= {ix, 2'h0};
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [9:0] ix, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr  <= {ix, 2'h0};
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    chk("prsnt_n", 32'h1, prsnt_n);
    chk("mode", 32'h0, mode_pcie);
    rd(IDX_SUPPLY_CTRL, d, r);
    chk("supply", 32'h0, d);
    rd(IDX_ALT_LINK, d, r);
    chk("link", 32'h0, d);
    wr(IDX_CAPS_LO, WORD_ZERO, r);
    chk("ro resp", RESP_OKAY, r);
    rd(IDX_CAPS_LO, d, r);
    chk("dual cap", 32'h1, d[CAP_DUAL_BIT]);
    rd(IDX_CAPS_HI, d, r);
    chk("rail cap", 32'h1, d[CAP_LOWRAIL_BIT - CAP_HI_BASE]);
    rd(10'h3ff, d, r);
    chk("unmapped", RESP_SLVERR, r);
  endtask

  task automatic t_insert;
    logic [31:0] d;
    logic [1:0]  r;
    inserted <= 1'h1;
    repeat (5) @(posedge aclk);
    chk("detect", 32'h0, sdc_card_detect_n);
    chk("second off", 32'h0, second_supply_en);
    rd(IDX_EVT_STATUS, d, r);
    chk("insert evt", 32'h1, d[EV_INSERT]);
    chk("irq masked", 32'h0, irq);
    wr(IDX_EVT_MASK, 32'h1, r);
    repeat (2) @(posedge aclk);
    chk("irq on", 32'h1, irq);
    wr(IDX_EVT_STATUS, 32'h1, r);
    repeat (2) @(posedge aclk);
    chk("irq clear", 32'h0, irq);
  endtask

  task automatic t_legacy;
    sdc_dat_oe <= 4'hf;
    sdc_dat_o  <= 4'ha;
    sd_reply   <= 4'h6;
    repeat (2) @(posedge aclk);
    chk("sd out", 32'ha, card_dat_o);
    sdc_dat_oe <= 4'h0;
    repeat (2) @(posedge aclk);
    chk("sd in", 32'h6, sdc_dat_i);
  endtask

  task automatic t_link;
    logic [31:0] d;
    logic [1:0]  r;
    wr(IDX_SUPPLY_CTRL, 32'h11, r);
    chk("first only", 32'h1, first_supply_en);
    chk("second held", 32'h0, second_supply_en);
    wr(IDX_SUPPLY_CTRL, 32'h11, r);
    chk("second on", 32'h1, second_supply_en);
    chk("link mode", 32'h1, mode_pcie);
    perst_n <= 1'h0;
    repeat (2) @(posedge aclk);
    chk("reset pin", 32'h0, card_dat_o[3]);
    chk("sd isolated", 32'hf, sdc_dat_i);
    chk("ref pair", 32'h2, card_dat_o[1:0]);
    wr(IDX_ALT_LINK, 32'h1, r);
    chk("present", 32'h0, prsnt_n);
    wr(IDX_ALT_LINK, 32'h0, r);
    chk("absent", 32'h1, prsnt_n);
    wr(IDX_ALT_LINK, 32'h3, r);
    rd(IDX_ALT_LINK, d, r);
    chk("link rb", 32'h3, d);
    rd(IDX_PIN_STATE, d, r);
    chk("pins", 32'h2f, d);
  endtask

  task automatic t_clkreq;
    logic [31:0] d;
    logic [1:0]  r;
    card_pull <= 1'h1;
    repeat (5) @(posedge aclk);
    chk("card pull", 32'h0, clkreq_n_sense);
    rd(IDX_EVT_STATUS, d, r);
    chk("clkreq evt", 32'h1, d[EV_CLKREQ]);
    card_pull   <= 1'h0;
    clkreq_pull <= 1'h1;
    repeat (5) @(posedge aclk);
    chk("host pull", 32'h0, clkreq_n_sense);
    clkreq_pull <= 1'h0;
    repeat (5) @(posedge aclk);
    chk("pull-up", 32'h1, clkreq_n_sense);
    ref_run <= 1'h1;
    repeat (100) @(posedge aclk);
    ref_run <= 1'h0;
    repeat (60) @(posedge aclk);
    rd(IDX_EVT_STATUS, d, r);
    chk("stall evt", 32'h1, d[EV_REFSTALL]);
  endtask

  task automatic t_remove;
    logic [31:0] d;
    logic [1:0]  r;
    inserted <= 1'h0;
    repeat (6) @(posedge aclk);
    chk("rails off", 32'h0, {first_supply_en, second_supply_en});
    chk("gone", 32'h1, prsnt_n);
    rd(IDX_EVT_STATUS, d, r);
    chk("remove evt", 32'h1, d[EV_REMOVE]);
    wr(IDX_SUPPLY_CTRL, 32'h11, r);
    chk("no card rail", 32'h0, second_supply_en);
  endtask

  // ****************************************************************
  // Sequence, watchdog and verdict
  // ****************************************************************
  task automatic wrap_up;
    $display("Checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_insert();
    t_legacy();
    t_link();
    t_clkreq();
    t_remove();
    wrap_up();
  end

  // Hang guard
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      wrap_up();
    end
  end
endmodule
